// File: rtl/tmb_consts.vh
/*
 * Constants of the timer base and port A pin select block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes inclusion by the design, checker and bench files; definitions only.
 */
`ifndef TMB_CONSTS_VH
`define TMB_CONSTS_VH

// Register offsets on the 8-bit register port
`define TMB_A_PORTA_DATA 8'h00
`define TMB_A_PORTA_DIR  8'h01
`define TMB_A_C45_HI     8'h1e
`define TMB_A_C45_LO     8'h1f
`define TMB_A_COUNT_HI   8'h0e
`define TMB_A_COUNT_LO   8'h0f
`define TMB_A_MASK       8'h24
`define TMB_A_FLAG       8'h25
`define TMB_A_ACC_CTRL   8'h26

// Field positions
`define TMB_B_WRAP_FLAG  7
`define TMB_B_WRAP_EN    7
`define TMB_B_DIV_HI     1
`define TMB_B_DIV_LO     0
`define TMB_B_P3_CAPSEL  2

// Reset values
`define TMB_R_BYTE       8'h00
`define TMB_R_COUNT      16'h0000
`define TMB_R_DIV        2'h0

// Prescale divisor codes
`define TMB_DIV_1        2'h0
`define TMB_DIV_4        2'h1
`define TMB_DIV_8        2'h2
`define TMB_DIV_16       2'h3

// Low chain bits that must be all ones for a main tick
`define TMB_M_DIV_1      4'h0
`define TMB_M_DIV_4      4'h3
`define TMB_M_DIV_8      4'h7
`define TMB_M_DIV_16     4'hf

// Divisor write window after reset, in bus cycles
`define TMB_DIV_WINDOW   7'h40

// Post-scale taps: highest chain bit of each all-ones window
`define TMB_ACC_TOP      5
`define TMB_PER_TOP      12
`define TMB_WDG_TOP      14

`endif

// File: rtl/tmb_top.v
/*
 * Timer base and port A pin select: prescaler, main timer tick,
 * 16-bit free-running counter with wrap flag and request, post-scaled
 * taps for accumulator, periodic interrupt and watchdog, and the port A
 * pin mux shared between general I/O and timer channels.
 * Assumes a synchronous register port (read data one cycle after the
 * read strobe), synchronous pin inputs and compare channel levels and
 * enables supplied by the capture/compare datapaths outside.
 */
// Decided for this implementation: strobed register access.
//
// Function
// - Divisor code selects prescale 1, 4, 8, 16
// - Main tick drives counter; bus cycles drive the chain
// - Counter starts at zero, wraps, keeps counting
// - Wrap flag set on all ones to zero
// - Normal mode ignores count register writes
// - Special mode allows count register read/write
// - Writing one clears flag, zero keeps it
// - Wrap request when flag and enable set
// - Normal mode: one divisor write, 64 cycles
// - Accumulator clock is bus clock over 64
// - Periodic clock is bus clock over 8192
// - Watchdog clock is periodic clock over four
// - Port read: pin level in, driver out
// - Timer pins latch writes, do not drive
// - Pins 0-2 capture, 4-6 compare, or GPIO
// - Pin 3 GPIO, capture 4, compare 5/1
// - Compare one drives pins 3-7; pin 7 accumulator
// - Pin 3 select: 0 compare five, 1 capture four
// - Output pin 3 plus capture: write captures
// - Input pin 3 or compare five: write ignored
`timescale 1ns/1ps
`include "tmb_consts.vh"

module tmb_top (
	// Clock and reset
	input  wire        sys_clk_i,
	input  wire        rst_i,
	// Operating mode: high in special modes
	input  wire        special_mode_i,
	// Register port
	input  wire [7:0]  addr_i,
	input  wire [7:0]  wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output wire [7:0]  rdata_o,
	// Port A pins
	input  wire [7:0]  porta_in_i,
	output wire [7:0]  porta_out_o,
	output wire [7:0]  porta_oe_o,
	// Compare channel levels, index 0 is channel one
	input  wire [4:0]  cmp_level_i,
	// Compare channels two to five have pin action enabled
	input  wire [3:0]  cmp_pin_en_i,
	// Compare channel one pin mask, bit 0 is pin 3
	input  wire [4:0]  cmp1_mask_i,
	// Capture channel four edge detection enabled
	input  wire        cap4_en_i,
	// Timebase ticks
	output wire        main_tick_o,
	output wire        accum_tick_o,
	output wire        periodic_tick_o,
	output wire        watchdog_tick_o,
	// Counter state
	output wire [15:0] free_run_count_o,
	output wire        wrap_irq_o,
	// Pin 3 role and shared register write effects
	output wire        pin3_capture_select_o,
	output wire        soft_capture_o,
	output wire        c45_write_o,
	output wire [7:0]  c45_wdata_o,
	output wire        c45_write_hi_o
);

	// Bus cycle chain, low bits feed the prescaler
	reg  [14:0] tick_chain_ff;
	// Free-running count
	reg  [15:0] free_run_count_ff;
	// Wrap flag and its enable
	reg         counter_wrap_flag_ff;
	reg         wrap_irq_enable_ff;
	// Divisor code and its lock
	reg  [1:0]  tick_divisor_select_ff;
	reg         div_locked_ff;
	// Cycles since reset, saturates at the window
	reg  [6:0]  win_cnt_ff;
	// Port A data latch and direction
	reg  [7:0]  porta_data_ff;
	reg  [7:0]  porta_direction_ff;
	// Accumulator control register
	reg  [7:0]  accum_ctrl_ff;
	// Registered pin drive
	reg  [7:0]  porta_out_ff;
	reg  [7:0]  porta_oe_ff;
	// Read data
	reg  [7:0]  rdata_ff;
	// Shared register write effects
	reg         soft_capture_ff;
	reg         c45_write_ff;
	reg         c45_write_hi_ff;
	reg  [7:0]  c45_wdata_ff;

	// Combinational terms
	reg  [3:0]  div_mask;
	wire        main_tick;
	wire        wrap_event;
	wire        wr_count_hi;
	wire        wr_count_lo;
	wire        wr_flag;
	wire        wr_mask;
	wire        div_write_ok;
	wire        pin3_dir;
	wire        capsel;
	wire        c45_access;
	wire        c45_accept;
	reg  [7:0]  nxt_rdata;
	// Per-pin timer ownership and timer level
	wire [7:0]  tmr_own;
	wire [7:0]  tmr_lvl;
	wire [7:0]  nxt_porta_out;
	wire [7:0]  nxt_porta_oe;

	// Chain mask for the selected divisor
	always @* begin
		case (tick_divisor_select_ff)
			`TMB_DIV_1: div_mask = `TMB_M_DIV_1;
			`TMB_DIV_4: div_mask = `TMB_M_DIV_4;
			`TMB_DIV_8: div_mask = `TMB_M_DIV_8;
			default:    div_mask = `TMB_M_DIV_16;
		endcase
	end

	// Main tick once per divisor bus cycles
	// The chain is never restarted on a divisor change, so the taps
	// below keep their rate whatever code software picks
	assign main_tick =
		((tick_chain_ff[3:0] & div_mask) == div_mask);

	// Bus cycle chain, free from reset
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_chain_ff <= 15'h0000;
		end else begin
			tick_chain_ff <= tick_chain_ff + 15'h0001;
		end
	end

	// Post-scaled taps, each a subset of main ticks
	assign accum_tick_o = main_tick &
		(&tick_chain_ff[`TMB_ACC_TOP:0]);
	assign periodic_tick_o = main_tick &
		(&tick_chain_ff[`TMB_PER_TOP:0]);
	// Every fourth periodic tick
	assign watchdog_tick_o = main_tick &
		(&tick_chain_ff[`TMB_WDG_TOP:0]);
	assign main_tick_o = main_tick;

	// Register port decodes
	assign wr_count_hi = wr_i & (addr_i == `TMB_A_COUNT_HI);
	assign wr_count_lo = wr_i & (addr_i == `TMB_A_COUNT_LO);
	assign wr_flag     = wr_i & (addr_i == `TMB_A_FLAG);
	assign wr_mask     = wr_i & (addr_i == `TMB_A_MASK);

	// Wrap occurs on a tick from all ones
	assign wrap_event = main_tick &
		(free_run_count_ff == 16'hffff);

	// Free-running counter
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			free_run_count_ff <= `TMB_R_COUNT;
		end else if (special_mode_i & wr_count_hi) begin
			free_run_count_ff[15:8] <= wdata_i;
		end else if (special_mode_i & wr_count_lo) begin
			free_run_count_ff[7:0] <= wdata_i;
		end else if (main_tick) begin
			// Count by one, rolls to zero past all ones
			free_run_count_ff <=
				free_run_count_ff + 16'h0001;
		end
	end
	// Normal-mode writes to the count fall through above

	// Wrap flag, set wins over a same-cycle clear
	// A clear landing in the wrap cycle must not swallow the new
	// event, so the set branch is tested first
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			counter_wrap_flag_ff <= 1'b0;
		end else if (wrap_event) begin
			counter_wrap_flag_ff <= 1'b1;
		end else if (wr_flag & wdata_i[`TMB_B_WRAP_FLAG]) begin
			counter_wrap_flag_ff <= 1'b0;
		end
	end

	// Request follows flag and enable
	assign wrap_irq_o = counter_wrap_flag_ff &
		wrap_irq_enable_ff;

	// Divisor write allowed once inside the window, or in special
	// Special modes may rewrite the code at any time
	assign div_write_ok = special_mode_i |
		(~div_locked_ff & (win_cnt_ff < `TMB_DIV_WINDOW));

	// Cycles since reset, stops at the window length
	// Saturating keeps the counter small; once at the limit the
	// divisor stays locked in normal modes until the next reset
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			win_cnt_ff <= 7'h00;
		end else if (win_cnt_ff < `TMB_DIV_WINDOW) begin
			win_cnt_ff <= win_cnt_ff + 7'h01;
		end
	end

	// Mask register: enable bit and locked divisor
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wrap_irq_enable_ff     <= 1'b0;
			tick_divisor_select_ff <= `TMB_R_DIV;
			div_locked_ff          <= 1'b0;
		end else if (wr_mask) begin
			wrap_irq_enable_ff <= wdata_i[`TMB_B_WRAP_EN];
			if (div_write_ok) begin
				// Take the code, then lock it
				tick_divisor_select_ff <=
					wdata_i[`TMB_B_DIV_HI:`TMB_B_DIV_LO];
				div_locked_ff <= 1'b1;
			end
		end
	end

	// Port A data, direction and accumulator control
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			porta_data_ff      <= `TMB_R_BYTE;
			porta_direction_ff <= `TMB_R_BYTE;
			accum_ctrl_ff      <= `TMB_R_BYTE;
		end else if (wr_i) begin
			case (addr_i)
				// Latched even for timer pins
				`TMB_A_PORTA_DATA: porta_data_ff <= wdata_i;
				`TMB_A_PORTA_DIR: porta_direction_ff <= wdata_i;
				`TMB_A_ACC_CTRL: accum_ctrl_ff <= wdata_i;
				default: ;
			endcase
		end
	end

	// Pin 3 role controls
	assign pin3_dir = porta_direction_ff[3];
	assign capsel   = accum_ctrl_ff[`TMB_B_P3_CAPSEL];
	assign pin3_capture_select_o = capsel;

	// Timer ownership: capture pins never taken for drive
	assign tmr_own[2:0] = 3'h0;
	// Pin 3: compare one, or compare five when not capture
	assign tmr_own[3] = cmp1_mask_i[0] |
		(~capsel & cmp_pin_en_i[3]);
	// Pins 4-6: compare two to four, or compare one
	assign tmr_own[6:4] = cmp_pin_en_i[2:0] |
		cmp1_mask_i[3:1];
	// Pin 7: compare one only, else GPIO or accumulator input
	assign tmr_own[7] = cmp1_mask_i[4];

	// Timer level: compare one overrides the other channel
	assign tmr_lvl[2:0] = 3'h0;
	assign tmr_lvl[3] = cmp1_mask_i[0] ?
		cmp_level_i[0] : cmp_level_i[4];
	assign tmr_lvl[7] = cmp_level_i[0];

	// Per-pin drive mux
	// Pins 0-2 stay with the data latch; capture needs no driver
	genvar gi;
	generate
		for (gi = 4; gi < 7; gi = gi + 1) begin : g_cmp_lvl
			// Compare one or own compare channel
			assign tmr_lvl[gi] = cmp1_mask_i[gi-3] ?
				cmp_level_i[0] : cmp_level_i[gi-3];
		end
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
			// Timer pins drive timer level, not the latch
			assign nxt_porta_out[gi] = tmr_own[gi] ?
				tmr_lvl[gi] : porta_data_ff[gi];
			assign nxt_porta_oe[gi] = tmr_own[gi] |
				porta_direction_ff[gi];
		end
	endgenerate

	// Registered pin drive
	// Registering keeps glitches of the channel inputs off the
	// pins, at the cost of one cycle of lag
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			porta_out_ff <= `TMB_R_BYTE;
			porta_oe_ff  <= `TMB_R_BYTE;
		end else begin
			porta_out_ff <= nxt_porta_out;
			porta_oe_ff  <= nxt_porta_oe;
		end
	end
	assign porta_out_o = porta_out_ff;
	assign porta_oe_o  = porta_oe_ff;

	// Shared capture four / compare five register writes
	assign c45_access = wr_i & ((addr_i == `TMB_A_C45_HI) |
		(addr_i == `TMB_A_C45_LO));
	// Software relies on direction and select matching
	assign c45_accept = c45_access & pin3_dir & capsel;

	// Write effects on the shared register
	// The byte and its half are staged on every access; only the
	// strobe tells the outside datapath whether to take them
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			soft_capture_ff <= 1'b0;
			c45_write_ff    <= 1'b0;
			c45_write_hi_ff <= 1'b0;
			c45_wdata_ff    <= `TMB_R_BYTE;
		end else begin
			// Output pin with capture on: forced capture
			soft_capture_ff <= c45_accept & cap4_en_i;
			// Passed on only when not refused
			c45_write_ff    <= c45_accept;
			if (c45_access) begin
				c45_write_hi_ff <= (addr_i == `TMB_A_C45_HI);
				c45_wdata_ff    <= wdata_i;
			end
		end
	end
	assign soft_capture_o = soft_capture_ff;
	assign c45_write_o    = c45_write_ff;
	assign c45_write_hi_o = c45_write_hi_ff;
	assign c45_wdata_o    = c45_wdata_ff;

	// Read mux
	always @* begin
		nxt_rdata = 8'h00;
		case (addr_i)
			// Pin level for inputs, driver level for outputs
			`TMB_A_PORTA_DATA: nxt_rdata = (porta_oe_ff &
				porta_out_ff) | (~porta_oe_ff & porta_in_i);
			`TMB_A_PORTA_DIR: nxt_rdata = porta_direction_ff;
			`TMB_A_COUNT_HI: nxt_rdata = free_run_count_ff[15:8];
			`TMB_A_COUNT_LO: nxt_rdata = free_run_count_ff[7:0];
			`TMB_A_FLAG: nxt_rdata[`TMB_B_WRAP_FLAG] =
				counter_wrap_flag_ff;
			`TMB_A_MASK: begin
				nxt_rdata[`TMB_B_WRAP_EN] = wrap_irq_enable_ff;
				nxt_rdata[`TMB_B_DIV_HI:`TMB_B_DIV_LO] =
					tick_divisor_select_ff;
			end
			`TMB_A_ACC_CTRL: nxt_rdata = accum_ctrl_ff;
			default: nxt_rdata = 8'h00;
		endcase
	end

	// Read data stands for one cycle after the strobe
	// Zero outside the answer cycle keeps stale data off the bus
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff <= 8'h00;
		end else if (rd_i) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 8'h00;
		end
	end
	assign rdata_o = rdata_ff;
	assign free_run_count_o = free_run_count_ff;

endmodule // tmb_top

// File: bench/tmb_pins.sv
/* Far side of port A: the level on each pin.
   Assumes drive and enable from the block, source levels from the bench. */
`timescale 1ns/1ps
module tmb_pins (
	// Block drive
	input  wire [7:0] drive_i,
	input  wire [7:0] oe_i,
	// Outside source levels
	input  wire [7:0] ext_i,
	// Resolved pin levels
	output wire [7:0] pin_o
);
	// Driven pins follow the block, the rest the outside source
	assign pin_o = (drive_i & oe_i) | (ext_i & ~oe_i);
endmodule // tmb_pins

// File: bench/tmb_top_sva.sv
/* Checker for the timer base: timing and gating seen at the ports.
   Assumes one clock, async active-high reset, bound to tmb_top. */
`timescale 1ns/1ps
`include "tmb_consts.vh"
module tmb_top_chk (
	// Clock, reset, mode and register port
	input wire        sys_clk_i,
	input wire        rst_i,
	input wire [7:0]  addr_i,
	input wire [7:0]  wdata_i,
	input wire        wr_i,
	input wire        special_mode_i,
	input wire        cap4_en_i,
	// Watched outputs
	input wire [7:0]  porta_oe_o,
	input wire        main_tick_o,
	input wire        accum_tick_o,
	input wire        periodic_tick_o,
	input wire        watchdog_tick_o,
	input wire [15:0] free_run_count_o,
	input wire        wrap_irq_o,
	input wire        pin3_capture_select_o,
	input wire        soft_capture_o,
	input wire        c45_write_o
);
	// Bus cycles since reset release
	reg  [14:0] cyc_ff;
	wire [14:0] nxt_cyc = cyc_ff + 15'h0001;
	// Shared register write strobe
	wire        c45_wr = wr_i && addr_i[7:1] == 7'h0f;
	// Cycle counter
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cyc_ff <= 15'h0000;
		end else begin
			cyc_ff <= nxt_cyc;
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	accum_rate_a:
	assert property (accum_tick_o == (&cyc_ff[5:0] & main_tick_o))
		else $error("accumulator tick off rate");
	periodic_rate_a:
	assert property (periodic_tick_o == (&cyc_ff[12:0] & main_tick_o))
		else $error("periodic tick off rate");
	watchdog_rate_a:
	assert property (watchdog_tick_o == (&cyc_ff & main_tick_o))
		else $error("watchdog tick off rate");
	count_step_a:
	assert property (!rst_i && !special_mode_i |=> free_run_count_o ==
		$past(free_run_count_o) + {15'h0000, $past(main_tick_o)})
		else $error("count step wrong");
	wrap_zero_a:
	assert property (&free_run_count_o && main_tick_o && !wr_i
		|=> free_run_count_o == 16'h0000) else $error("no wrap");
	irq_cause_a:
	assert property ($rose(wrap_irq_o) |-> $past(&free_run_count_o &&
		main_tick_o) || $past(wr_i && addr_i == `TMB_A_MASK && wdata_i[7]))
		else $error("request without cause");
	dir_pins_a:
	assert property (wr_i && addr_i == `TMB_A_PORTA_DIR ##1
		!(wr_i && addr_i == `TMB_A_PORTA_DIR) |=>
		porta_oe_o[2:0] == $past(wdata_i[2:0], 2))
		else $error("pin enable not direction");
	select_track_a:
	assert property (wr_i && addr_i == `TMB_A_ACC_CTRL
		|=> pin3_capture_select_o == $past(wdata_i[2]))
		else $error("pin three select wrong");
	soft_cap_a:
	assert property (soft_capture_o |-> $past(c45_wr && cap4_en_i &&
		pin3_capture_select_o)) else $error("capture without cause");
	c45_gate_a:
	assert property ($past(c45_wr && !pin3_capture_select_o)
		|-> !c45_write_o) else $error("refused write accepted");
	cover property (soft_capture_o);
	cover property ($rose(wrap_irq_o));
	cover property (c45_write_o && !soft_capture_o);
endmodule // tmb_top_chk
bind tmb_top tmb_top_chk tmb_top_chk_i (
	.sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .cap4_en_i,
	.porta_oe_o, .main_tick_o, .accum_tick_o, .periodic_tick_o,
	.watchdog_tick_o, .free_run_count_o, .wrap_irq_o,
	.pin3_capture_select_o, .soft_capture_o, .c45_write_o,
	.special_mode_i
);

// File: bench/timer_base_and_pin_select_test.sv
/* Self-checking bench for the timer base and port A pin select.
   Assumes tmb_top, the pin model and the bound checker. */
`timescale 1ns/1ps
`include "tmb_consts.vh"
module timer_base_and_pin_select_test;
	// Block inputs
	reg         sys_clk_i = 1'b0;
	reg         rst_i = 1'b1;
	reg         special_mode_i = 1'b0;
	reg  [7:0]  addr_i = 8'h00;
	reg  [7:0]  wdata_i = 8'h00;
	reg         wr_i = 1'b0;
	reg         rd_i = 1'b0;
	reg  [4:0]  cmp_level_i = 5'h00;
	reg  [3:0]  cmp_pin_en_i = 4'h0;
	reg  [4:0]  cmp1_mask_i = 5'h00;
	reg         cap4_en_i = 1'b0;
	reg  [7:0]  ext_lvl = 8'h00;
	// Block outputs
	wire [7:0]  rdata_o, porta_in, porta_out_o, porta_oe_o, c45_wdata_o;
	wire [15:0] free_run_count_o;
	wire        main_tick_o, soft_capture_o, c45_write_o, wrap_irq_o;
	wire        pin3_capture_select_o, c45_write_hi_o;
	// Bench state
	integer     fail_count = 0;
	integer     checked = 0;
	integer     seed = 32'hf8dc;
	integer     cyc = 0;
	integer     i;
	logic [7:0] exp_q[$];
	logic       rd_seen = 1'b0;
	logic [7:0] w, d, l;
	tmb_top tmb_top_i (
		.sys_clk_i, .rst_i, .special_mode_i, .addr_i, .wdata_i, .wr_i,
		.rd_i, .rdata_o, .porta_in_i(porta_in), .porta_out_o, .porta_oe_o,
		.cmp_level_i, .cmp_pin_en_i, .cmp1_mask_i, .cap4_en_i,
		.main_tick_o, .accum_tick_o(), .periodic_tick_o(),
		.watchdog_tick_o(), .free_run_count_o, .wrap_irq_o,
		.pin3_capture_select_o, .soft_capture_o, .c45_write_o,
		.c45_wdata_o, .c45_write_hi_o
	);
	tmb_pins tmb_pins_i (.drive_i(porta_out_o), .oe_i(porta_oe_o),
		.ext_i(ext_lvl), .pin_o(porta_in));
	// Clock
	initial begin
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	// Compare and count
	task automatic check(input string name, input logic [15:0] seen, e);
		checked = checked + 1;
		if (seen !== e) begin
			fail_count = fail_count + 1;
			$display("wrong value %s expected %h seen %h", name, e, seen);
		end
	endtask
	// One bus cycle, then one idle cycle; reads note their expected data
	task automatic bus(input logic wr, input logic [7:0] a, v, e);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= wr;
		rd_i <= !wr;
		if (!wr) exp_q.push_back(e);
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
	endtask
	// Main ticks over 64 bus cycles
	task automatic ticks(input logic [15:0] e);
		logic [15:0] n;
		n = 16'h0000;
		repeat (64) begin
			@(posedge sys_clk_i);
			n = n + main_tick_o;
		end
		check("main ticks", n, e);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Read data watcher and hang limit
	always @(posedge sys_clk_i) begin
		if (rd_seen) check("read data", rdata_o, exp_q.pop_front());
		rd_seen = rd_i;
		cyc = cyc + 1;
		if (cyc > 5000) begin
			fail_count = fail_count + 1;
			tally_and_finish;
		end
	end
	initial begin
		repeat (5) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		bus(1'b1, `TMB_A_MASK, 8'h03, 8'h00);
		ticks(16'h0004);
		bus(1'b1, `TMB_A_MASK, 8'h01, 8'h00);
		ticks(16'h0004);
		bus(1'b0, `TMB_A_MASK, 8'h00, 8'h03);
		bus(1'b1, `TMB_A_COUNT_LO, 8'h55, 8'h00);
		bus(1'b0, 8'h77, 8'h00, 8'h00);
		// Port A: mixed directions, then timer drive over latched data
		w = $random(seed);
		d = $random(seed);
		ext_lvl <= $random(seed);
		bus(1'b1, `TMB_A_PORTA_DIR, d, 8'h00);
		bus(1'b1, `TMB_A_PORTA_DATA, w, 8'h00);
		bus(1'b0, `TMB_A_PORTA_DATA, 8'h00, (w & d) | (ext_lvl & ~d));
		l = $random(seed);
		cmp_level_i <= l[4:0];
		cmp_pin_en_i <= 4'hf;
		cmp1_mask_i <= 5'h11;
		bus(1'b1, `TMB_A_PORTA_DIR, 8'hff, 8'h00);
		bus(1'b0, `TMB_A_PORTA_DATA, 8'h00,
			{l[0], l[3:1], l[0], w[2:0]});
		// Pin three without compare one: compare five drives it
		cmp1_mask_i <= 5'h10;
		bus(1'b0, `TMB_A_PORTA_DATA, 8'h00,
			{l[0], l[3:1], l[4], w[2:0]});
		cmp_pin_en_i <= 4'h0;
		cmp1_mask_i <= 5'h00;
		bus(1'b0, `TMB_A_PORTA_DATA, 8'h00, w);
		// Pin three: every direction, select and capture enable
		for (i = 0; i < 8; i = i + 1) begin
			w = $random(seed);
			cap4_en_i <= i[2];
			bus(1'b1, `TMB_A_PORTA_DIR, {4'h0, i[0], 3'h0}, 8'h00);
			bus(1'b1, `TMB_A_ACC_CTRL, {5'h00, i[1], 2'h0}, 8'h00);
			@(negedge sys_clk_i);
			check("pin3 select", pin3_capture_select_o, i[1]);
			bus(1'b1, i[0] ? `TMB_A_C45_HI : `TMB_A_C45_LO, w, 8'h00);
			@(posedge sys_clk_i);
			check("shared half", c45_write_hi_o, i[0]);
			check("shared write", c45_write_o, &i[1:0]);
			check("soft capture", soft_capture_o, &i[2:0]);
			if (&i[1:0]) check("shared data", c45_wdata_o, w);
		end
		// Special mode: every divisor, then count write and wrap
		special_mode_i <= 1'b1;
		for (i = 0; i < 4; i = i + 1) begin
			bus(1'b1, `TMB_A_MASK, {6'h00, i[1:0]}, 8'h00);
			ticks(i == 0 ? 16'h0040 : 16'h0040 >> (i + 1));
		end
		bus(1'b1, `TMB_A_MASK, 8'h00, 8'h00);
		bus(1'b1, `TMB_A_COUNT_LO, 8'hf0, 8'h00);
		bus(1'b1, `TMB_A_COUNT_HI, 8'hff, 8'h00);
		bus(1'b0, `TMB_A_COUNT_HI, 8'h00, 8'hff);
		repeat (30) @(posedge sys_clk_i);
		bus(1'b0, `TMB_A_FLAG, 8'h00, 8'h80);
		check("wrap request", wrap_irq_o, 1'b0);
		bus(1'b1, `TMB_A_MASK, 8'h80, 8'h00);
		@(negedge sys_clk_i);
		check("wrap request", wrap_irq_o, 1'b1);
		bus(1'b1, `TMB_A_FLAG, 8'h00, 8'h00);
		bus(1'b0, `TMB_A_FLAG, 8'h00, 8'h80);
		bus(1'b1, `TMB_A_FLAG, 8'h80, 8'h00);
		bus(1'b0, `TMB_A_FLAG, 8'h00, 8'h00);
		@(negedge sys_clk_i);
		check("wrap request", wrap_irq_o, 1'b0);
		// Let the last read answer reach the watcher
		repeat (2) @(posedge sys_clk_i);
		check("reads left", exp_q.size(), 16'h0000);
		tally_and_finish;
	end
endmodule // timer_base_and_pin_select_test
